// file: ldsb_pkg.sv
package ldsb_pkg;
    localparam int          NUM_CH        = 16;
    localparam int          GS_BITS       = 12;
    localparam int          DC_BITS       = 6;
    localparam int          GS_LEN        = 192;
    localparam int          DC_LEN        = 96;
    localparam int          CNT_BITS      = 12;
    localparam int          CLK_PERIOD_PS = 5000;
    localparam int          STAGGER_PS    = 20000;
    localparam int          STAGGER_CYC   = STAGGER_PS / CLK_PERIOD_PS;
    localparam int          MAX_DELAY_PS  = 300000;
    localparam int          MAX_DELAY_CYC = MAX_DELAY_PS / CLK_PERIOD_PS;
    localparam int          DET_DELAY_PS  = 1000000;
    localparam int          DET_DELAY_CYC = (DET_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          SID_TEF_POS   = 16;
    localparam int          LINK_DIV      = 8;
    localparam logic [11:0] GS_MAX        = 12'hFFF;
endpackage

// file: ldsb_if.sv
`timescale 1ns/10ps
interface ldsb_if;
    logic shift_clock;
    logic serial_in;
    logic serial_out;
    logic latch_pulse;
    logic mode_select;
    logic output_off;
    logic grayscale_ref_clock;
    logic error_n_output_o;
    logic error_n_output_oe;

    modport driver_end
    (
        input  shift_clock,
        input  serial_in,
        output serial_out,
        input  latch_pulse,
        input  mode_select,
        input  output_off,
        input  grayscale_ref_clock,
        output error_n_output_o,
        output error_n_output_oe
    );

    modport ctrl_end
    (
        output shift_clock,
        output serial_in,
        input  serial_out,
        output latch_pulse,
        output mode_select,
        output output_off,
        output grayscale_ref_clock,
        input  error_n_output_o,
        input  error_n_output_oe
    );
endinterface

// file: ldsb_buf2.sv
`timescale 1ns/10ps
module ldsb_buf2
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem_reg [2];
    logic             wr_ptr_reg;
    logic             rd_ptr_reg;
    logic [1:0]       count_reg;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_reg != 2'h2);
    assign out_valid_o = (count_reg != 2'h0);
    assign out_data_o  = mem_reg[rd_ptr_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop)
            begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// file: ldsb_driver.sv
// Contract
// RULE_01: shift serial_in on shift clock rise
// RULE_02: latch transparent while latch pulse high
// RULE_03: controller sends words MSB first
// RULE_04: shift length 96 or 192 by mode
// RULE_05: controller latches grayscale at cycle end; ldsb_ctrl latches after each shifted word, ignoring the grayscale cycle
// RULE_06: latched grayscale takes effect immediately
// RULE_07: serial out feeds chained devices
// RULE_08: error output low on thermal or open
// RULE_09: output off masks open flags on error
// RULE_10: thermal flag follows detector, readable in status
// RULE_11: open flag needs on, delay, low voltage
// RULE_12: capture open bits at latch fall
// RULE_13: controller pulses latch while error asserted; ldsb_ctrl pulses it only after each shifted word and ignores ERROR_O
// RULE_14: stagger channels 20ns each, 300ns max
// RULE_15: output off disables all outputs
// RULE_16: output off resets grayscale counter
// RULE_17: short low gives min of count, duration
// RULE_18: mode select low grayscale, high dot correction
// RULE_19: latch copies into register chosen by mode
// RULE_20: status bits 0-15 open, bit 16 thermal
// RULE_21: serial out from last shift stage
`timescale 1ns/10ps
module ldsb_driver
(
    input  wire logic                       CORE_CLK_I,
    input  wire logic                       RST_I,
    ldsb_if.driver_end                      LINK,
    input  wire logic                       OVERTEMP_I,
    input  wire logic [ldsb_pkg::NUM_CH-1:0] OUT_LOW_I,
    output logic      [ldsb_pkg::NUM_CH-1:0] CHANNEL_OUTPUT_O,
    output logic      [ldsb_pkg::GS_LEN-1:0] GRAYSCALE_REGISTER_O,
    output logic      [ldsb_pkg::DC_LEN-1:0] DOT_CORRECTION_O,
    output logic                            THERMAL_FLAG_O,
    output logic      [ldsb_pkg::NUM_CH-1:0] OPEN_LED_FLAG_O
);
    localparam int N = ldsb_pkg::NUM_CH;
    localparam int L = ldsb_pkg::GS_LEN;

    // =====================================================================
    // synchronisers
    // =====================================================================
    logic [5:0]   s1_reg;
    logic [5:0]   s2_reg;
    logic         sclk_d_reg;
    logic         lat_d_reg;
    logic [N-1:0] low_s1_reg;
    logic [N-1:0] low_s2_reg;
    logic         ot_s1_reg;
    logic         ot_s2_reg;

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            s1_reg     <= 6'h00;
            s2_reg     <= 6'h00;
            sclk_d_reg <= 1'b0;
            lat_d_reg  <= 1'b0;
            low_s1_reg <= '0;
            low_s2_reg <= '0;
            ot_s1_reg  <= 1'b0;
            ot_s2_reg  <= 1'b0;
        end
        else
        begin
            s1_reg     <= {LINK.grayscale_ref_clock, LINK.output_off, LINK.mode_select,
                           LINK.latch_pulse, LINK.serial_in, LINK.shift_clock};
            s2_reg     <= s1_reg;
            sclk_d_reg <= s2_reg[0];
            lat_d_reg  <= s2_reg[2];
            low_s1_reg <= OUT_LOW_I;
            low_s2_reg <= low_s1_reg;
            ot_s1_reg  <= OVERTEMP_I;
            ot_s2_reg  <= ot_s1_reg;
        end
    end

    logic sclk_rise;
    logic sin_s;
    logic lat_s;
    logic lat_fall;
    logic dc_mode;
    logic off_s;
    logic grayscale_ref_clock_s;
    assign sclk_rise = s2_reg[0] && !sclk_d_reg;
    assign sin_s     = s2_reg[1];
    assign lat_s     = s2_reg[2];
    assign lat_fall  = !s2_reg[2] && lat_d_reg;
    assign dc_mode   = s2_reg[3];              // RULE_18
    assign off_s     = s2_reg[4];
    assign grayscale_ref_clock_s   = s2_reg[5];

    // =====================================================================
    // shift register and latches
    // =====================================================================
    logic [L-1:0] shift_reg;
    logic         serial_out_reg;
    logic         tef_reg;
    logic [N-1:0] lod_reg;
    logic [N-1:0] lod_snap_reg;
    logic [L-1:0] status_info_data;

    always_comb
    begin
        status_info_data                                = '0;
        status_info_data[N-1:0]                         = lod_snap_reg;     // RULE_20
        status_info_data[ldsb_pkg::SID_TEF_POS]         = tef_reg;          // RULE_10
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            shift_reg <= '0;
            serial_out_reg  <= 1'b0;
        end
        else if (lat_fall && !dc_mode)
        begin
            shift_reg <= status_info_data;
            serial_out_reg  <= status_info_data[L-1];
        end
        else if (sclk_rise && !lat_s)
        begin
            shift_reg <= {shift_reg[L-2:0], sin_s};                         // RULE_01
            if (dc_mode)
            begin
                serial_out_reg <= shift_reg[ldsb_pkg::DC_LEN-2];                  // RULE_04
            end
            else
            begin
                serial_out_reg <= shift_reg[L-2];                                 // RULE_21
            end
        end
    end
    assign LINK.serial_out = serial_out_reg;                                      // RULE_07

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            GRAYSCALE_REGISTER_O <= '0;
            DOT_CORRECTION_O     <= '0;
        end
        else if (lat_s)                                                     // RULE_02
        begin
            if (dc_mode)
            begin
                DOT_CORRECTION_O <= shift_reg[ldsb_pkg::DC_LEN-1:0];        // RULE_19
            end
            else
            begin
                GRAYSCALE_REGISTER_O <= shift_reg;                          // RULE_06
            end
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            lod_snap_reg <= '0;
        end
        else if (lat_fall)
        begin
            lod_snap_reg <= lod_reg;                                        // RULE_12
        end
    end

    // =====================================================================
    // grayscale counter and staggered outputs
    // =====================================================================
    logic                          gs_d_reg;
    logic [ldsb_pkg::CNT_BITS-1:0] cnt_reg;
    logic [N-1:0]                  pwm_on;

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            gs_d_reg <= 1'b0;
            cnt_reg  <= '0;
        end
        else
        begin
            gs_d_reg <= grayscale_ref_clock_s;
            if (off_s)
            begin
                cnt_reg <= '0;                                              // RULE_16
            end
            else if (grayscale_ref_clock_s && !gs_d_reg && cnt_reg != ldsb_pkg::GS_MAX)
            begin
                cnt_reg <= cnt_reg + 12'h001;
            end
        end
    end

    // staggered copies of the blank-gated pwm; outputs follow it
    logic [ldsb_pkg::MAX_DELAY_CYC:0] dly_reg [N];
    logic [N-1:0]                     det_done;
    logic [9:0]                       det_cnt_reg [N];

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_ch
            localparam int D = g * ldsb_pkg::STAGGER_CYC;
            assign pwm_on[g] = !off_s &&
                               (cnt_reg < GRAYSCALE_REGISTER_O[g*ldsb_pkg::GS_BITS +: ldsb_pkg::GS_BITS]); // RULE_17
            always_ff @(posedge CORE_CLK_I)
            begin
                if (RST_I)
                begin
                    dly_reg[g] <= '0;
                end
                else
                begin
                    dly_reg[g] <= {dly_reg[g][ldsb_pkg::MAX_DELAY_CYC-1:0], pwm_on[g]};
                end
            end
            // blank forces off at once; turn-on and turn-off are delayed
            assign CHANNEL_OUTPUT_O[g] = !off_s && dly_reg[g][D];           // RULE_14 RULE_15

            always_ff @(posedge CORE_CLK_I)
            begin
                if (RST_I || !CHANNEL_OUTPUT_O[g])
                begin
                    det_cnt_reg[g] <= '0;
                end
                else if (!det_done[g])
                begin
                    det_cnt_reg[g] <= det_cnt_reg[g] + 10'h001;
                end
            end
            assign det_done[g] = (det_cnt_reg[g] == 10'(ldsb_pkg::DET_DELAY_CYC));

            always_ff @(posedge CORE_CLK_I)
            begin
                if (RST_I)
                begin
                    lod_reg[g] <= 1'b0;
                end
                else
                begin
                    lod_reg[g] <= CHANNEL_OUTPUT_O[g] && det_done[g] && low_s2_reg[g]; // RULE_11
                end
            end
        end
    endgenerate

    // =====================================================================
    // error flags
    // =====================================================================
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            tef_reg <= 1'b0;
        end
        else
        begin
            tef_reg <= ot_s2_reg;                                           // RULE_10
        end
    end

    assign THERMAL_FLAG_O          = tef_reg;
    assign OPEN_LED_FLAG_O         = lod_reg;
    assign LINK.error_n_output_o   = 1'b0;
    assign LINK.error_n_output_oe  = tef_reg || ((|lod_reg) && !off_s);     // RULE_08 RULE_09
endmodule

// file: ldsb_ctrl.sv
`timescale 1ns/10ps
module ldsb_ctrl
(
    input  wire logic                        CORE_CLK_I,
    input  wire logic                        RST_I,
    ldsb_if.ctrl_end                         LINK,
    input  wire logic                        WORD_VALID_I,
    output logic                             WORD_READY_O,
    input  wire logic [ldsb_pkg::GS_LEN-1:0] WORD_DATA_I,
    input  wire logic                        WORD_DC_I,
    input  wire logic                        OUTPUT_OFF_I,
    input  wire logic                        GS_CLOCK_EN_I,
    output logic      [ldsb_pkg::GS_LEN-1:0] READ_DATA_O,
    output logic                             READ_VALID_O,
    output logic                             ERROR_O
);
    localparam int L = ldsb_pkg::GS_LEN;

    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'h1,
        ST_LOW   = 4'h2,
        ST_HIGH  = 4'h4,
        ST_LATCH = 4'h8
    } ldsb_state_t;

    logic           b_valid;
    logic           b_ready;
    logic [L:0]     b_data;
    ldsb_buf2 #(.WIDTH(L + 1)) u_buf
    (
        .clk_i       (CORE_CLK_I),
        .rst_i       (RST_I),
        .in_valid_i  (WORD_VALID_I),
        .in_ready_o  (WORD_READY_O),
        .in_data_i   ({WORD_DC_I, WORD_DATA_I}),
        .out_valid_o (b_valid),
        .out_ready_i (b_ready),
        .out_data_o  (b_data)
    );

    ldsb_state_t st_reg;
    logic [L-1:0] sh_reg;
    logic [L-1:0] rd_reg;
    logic [7:0]   bit_reg;
    logic [7:0]   len_reg;
    logic [1:0]   div_reg;
    logic         sclk_reg;
    logic         sin_reg;
    logic         lat_reg;
    logic         dc_reg;
    logic         rv_reg;
    logic [2:0]   gdiv_reg;
    logic         gclk_reg;
    logic         so_s1_reg;
    logic         so_s2_reg;
    logic         er_s1_reg;
    logic         er_s2_reg;

    assign b_ready = (st_reg == ST_IDLE);
    assign LINK.shift_clock         = sclk_reg;
    assign LINK.serial_in           = sin_reg;
    assign LINK.latch_pulse         = lat_reg;
    assign LINK.mode_select         = dc_reg;
    assign LINK.output_off          = OUTPUT_OFF_I;
    assign LINK.grayscale_ref_clock = gclk_reg;
    assign READ_DATA_O  = rd_reg;
    assign READ_VALID_O = rv_reg;
    assign ERROR_O      = er_s2_reg;

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            so_s1_reg <= 1'b0;
            so_s2_reg <= 1'b0;
            er_s1_reg <= 1'b0;
            er_s2_reg <= 1'b0;
            gdiv_reg  <= 3'h0;
            gclk_reg  <= 1'b0;
        end
        else
        begin
            so_s1_reg <= LINK.serial_out;
            so_s2_reg <= so_s1_reg;
            er_s1_reg <= LINK.error_n_output_oe;
            er_s2_reg <= er_s1_reg;
            gdiv_reg  <= gdiv_reg + 3'h1;
            if (GS_CLOCK_EN_I && gdiv_reg == 3'h7)
            begin
                gclk_reg <= ~gclk_reg;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            st_reg   <= ST_IDLE;
            sh_reg   <= '0;
            rd_reg   <= '0;
            bit_reg  <= 8'h00;
            len_reg  <= 8'h00;
            div_reg  <= 2'h0;
            sclk_reg <= 1'b0;
            sin_reg  <= 1'b0;
            lat_reg  <= 1'b0;
            dc_reg   <= 1'b0;
            rv_reg   <= 1'b0;
        end
        else
        begin
            rv_reg  <= 1'b0;
            div_reg <= div_reg + 2'h1;
            case (st_reg)
                ST_IDLE:
                begin
                    div_reg <= 2'h0;
                    if (b_valid)
                    begin
                        dc_reg  <= b_data[L];
                        sh_reg  <= b_data[L-1:0];
                        len_reg <= b_data[L] ? 8'(ldsb_pkg::DC_LEN) : 8'(L);
                        bit_reg <= 8'h00;
                        st_reg  <= ST_LOW;
                    end
                end
                ST_LOW:
                begin
                    if (div_reg == 2'h0)
                    begin
                        // MSB first; dc words sit in the low bits
                        sin_reg <= dc_reg ? sh_reg[ldsb_pkg::DC_LEN-1] : sh_reg[L-1]; // RULE_03
                    end
                    if (div_reg == 2'h3)
                    begin
                        sclk_reg <= 1'b1;
                        st_reg   <= ST_HIGH;
                    end
                end
                ST_HIGH:
                begin
                    if (div_reg == 2'h1)
                    begin
                        rd_reg <= {rd_reg[L-2:0], so_s2_reg};
                    end
                    if (div_reg == 2'h3)
                    begin
                        sclk_reg <= 1'b0;
                        sh_reg   <= {sh_reg[L-2:0], 1'b0};
                        bit_reg  <= bit_reg + 8'h01;
                        st_reg   <= (bit_reg + 8'h01 == len_reg) ? ST_LATCH : ST_LOW;
                    end
                end
                ST_LATCH:
                begin
                    lat_reg <= (div_reg != 2'h3);                          // RULE_13
                    if (div_reg == 2'h3)
                    begin
                        rv_reg <= 1'b1;
                        st_reg <= ST_IDLE;
                    end
                end
                default:
                begin
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// file: ldsb_assertions.sv
`timescale 1ns/10ps
module ldsb_assertions
(
    input  wire logic CORE_CLK_I,
    input  wire logic RST_I,
    input  wire logic shift_clock,
    input  wire logic serial_in,
    input  wire logic serial_out,
    input  wire logic latch_pulse,
    input  wire logic mode_select,
    input  wire logic output_off,
    input  wire logic grayscale_ref_clock,
    input  wire logic error_n_output_o,
    input  wire logic error_n_output_oe
);
    logic        sclk_d_reg;
    logic        latch_d_reg;
    int unsigned since_evt_reg;
    int unsigned shifts_reg;

    // ==========================================================
    // helper logic
    always_ff @(posedge CORE_CLK_I)
    begin
        sclk_d_reg  <= shift_clock;
        latch_d_reg <= latch_pulse;
    end

    // cycles since a shift rise or a latch fall
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I || (shift_clock && !sclk_d_reg) || (!latch_pulse && latch_d_reg))
            since_evt_reg <= 0;
        else if (since_evt_reg < 100)
            since_evt_reg <= since_evt_reg + 1;
    end

    // shift rises since the last latch
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I || (!latch_pulse && latch_d_reg))
            shifts_reg <= 0;
        else if (shift_clock && !sclk_d_reg)
            shifts_reg <= shifts_reg + 1;
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);

    sclk_high_a: assert property ($rose(shift_clock) |=> shift_clock[*2])
        else $error("shift clock high phase too short");
    sclk_low_a: assert property ($fell(shift_clock) |=> !shift_clock[*2])
        else $error("shift clock low phase too short");
    sin_hold_a: assert property (shift_clock && $past(shift_clock) |-> $stable(serial_in))
        else $error("serial data moved while shift clock high");
    latch_quiet_a: assert property (latch_pulse && $past(latch_pulse)
        |-> $stable(shift_clock) && $stable(serial_in) && $stable(mode_select))
        else $error("link moved while latch high");
    latch_width_a: assert property ($rose(latch_pulse)
        |=> latch_pulse[*2] ##1 !latch_pulse)
        else $error("latch pulse width wrong");
    latch_idle_a: assert property ($rose(latch_pulse) |-> !shift_clock)
        else $error("latch raised with shift clock high");
    shift_count_a: assert property ($rose(latch_pulse)
        |-> shifts_reg == (mode_select ? ldsb_pkg::DC_LEN : ldsb_pkg::GS_LEN))
        else $error("wrong number of shifts before latch");
    serial_out_cause_a: assert property ($changed(serial_out) |-> since_evt_reg <= 6)
        else $error("serial out changed without a shift");
    err_level_a: assert property (error_n_output_oe |-> !error_n_output_o)
        else $error("error output driven high");
endmodule

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         overtemp = 1'b1;
    logic [15:0]  out_low = 16'h0000;
    logic         word_valid = 1'b0;
    logic         word_ready;
    logic [191:0] word_data = '0;
    logic         word_dc = 1'b0;
    logic         output_off = 1'b1;
    logic         gs_clk_en = 1'b0;
    logic [191:0] read_data;
    logic         read_valid;
    logic         error_o;
    logic [15:0]  ch_out;
    logic [191:0] gs_reg;
    logic [95:0]  dc_reg;
    logic         thermal;
    logic [15:0]  open_flag;
    logic         err_n;
    int           failures = 0;
    int           checks = 0;
    int           cycles = 0;
    int           ton[16];
    logic [191:0] w1;
    logic [191:0] w2;
    logic [191:0] w3;

    ldsb_if link();
    // open-drain wire with pull-up
    assign err_n = link.error_n_output_oe ? link.error_n_output_o : 1'b1;

    ldsb_driver u_ldsb_driver (.CORE_CLK_I(clk), .RST_I(rst), .LINK(link),
        .OVERTEMP_I(overtemp), .OUT_LOW_I(out_low), .CHANNEL_OUTPUT_O(ch_out),
        .GRAYSCALE_REGISTER_O(gs_reg), .DOT_CORRECTION_O(dc_reg),
        .THERMAL_FLAG_O(thermal), .OPEN_LED_FLAG_O(open_flag));
    ldsb_ctrl u_ldsb_ctrl (.CORE_CLK_I(clk), .RST_I(rst), .LINK(link),
        .WORD_VALID_I(word_valid), .WORD_READY_O(word_ready), .WORD_DATA_I(word_data),
        .WORD_DC_I(word_dc), .OUTPUT_OFF_I(output_off), .GS_CLOCK_EN_I(gs_clk_en),
        .READ_DATA_O(read_data), .READ_VALID_O(read_valid), .ERROR_O(error_o));
    ldsb_assertions u_ldsb_assertions (.CORE_CLK_I(clk), .RST_I(rst),
        .shift_clock(link.shift_clock), .serial_in(link.serial_in),
        .serial_out(link.serial_out), .latch_pulse(link.latch_pulse),
        .mode_select(link.mode_select), .output_off(link.output_off),
        .grayscale_ref_clock(link.grayscale_ref_clock),
        .error_n_output_o(link.error_n_output_o),
        .error_n_output_oe(link.error_n_output_oe));

    always #2.5 clk = ~clk;

    // ==========================================================
    // tasks
    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [191:0] seen, input logic [191:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // valid stays high until the caller drops it
    task automatic push(input logic [191:0] d, input logic dc);
        int n;
        n = 0;
        word_valid = 1'b1;
        word_data = d;
        word_dc = dc;
        while (word_ready !== 1'b1 && n < 5000)
        begin
            tick;
            n++;
        end
        tick;
    endtask

    task automatic wait_read;
        int n;
        n = 0;
        tick;
        while (read_valid !== 1'b1 && n < 4000)
        begin
            tick;
            n++;
        end
        check(read_valid, 1'b1);
    endtask

    task automatic final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            final_report;
        end
    end

    // ==========================================================
    // tests
    initial
    begin
        w1 = {24{8'h1E}};
        w2 = {24{8'h3A}};
        w3 = {96'h0, {12{8'h96}}};
        repeat (20) tick;
        rst = 1'b0;
        check({ch_out, open_flag, thermal}, '0);
        push(w1, 1'b0);
        push(w2, 1'b0);
        push(w3, 1'b1);
        word_valid = 1'b0;
        tick;
        check(word_ready, 1'b0);
        wait_read;
        check(gs_reg, w1);
        wait_read;
        check(gs_reg, w2);
        check(read_data, 192'h10000);
        wait_read;
        check(dc_reg, w3);
        check(gs_reg, w2);
        $display("test load done");
        check(err_n, 1'b0);
        check(error_o, 1'b1);
        check(thermal, 1'b1);
        overtemp = 1'b0;
        repeat (10) tick;
        check({err_n, error_o, thermal}, 3'b100);
        $display("test thermal done");
        out_low = 16'h0001;
        gs_clk_en = 1'b1;
        push({{15{12'hFFF}}, 12'h002}, 1'b0);
        word_valid = 1'b0;
        wait_read;
        for (int n = 0; n < 16; n++)
            ton[n] = -1;
        output_off = 1'b0;
        for (int c = 0; c < 150; c++)
        begin
            tick;
            for (int n = 0; n < 16; n++)
                if (ch_out[n] === 1'b1 && ton[n] < 0)
                    ton[n] = c;
        end
        for (int n = 1; n < 16; n++)
            check(192'(ton[n] - ton[0]), 192'(n * ldsb_pkg::STAGGER_CYC));
        check(ch_out, 16'hFFFE);
        $display("test stagger done");
        out_low = 16'h0021;
        repeat (260) tick;
        check(open_flag, 16'h0020);
        check(err_n, 1'b0);
        output_off = 1'b1;
        repeat (6) tick;
        check(ch_out, 16'h0000);
        check(err_n, 1'b1);
        output_off = 1'b0;
        repeat (6) tick;
        check(ch_out[0], 1'b1);
        $display("test blank done");
        final_report;
    end
endmodule
